// ### src/mtsc_regs.vh
// register offsets, field layouts and limits of the tx statistics block
// assumes word-indexed wishbone addressing: byte address = 4 * index
// Operation
// - upper byte-count register shows bits 47..32 in bits 15..0, rest zero.
// - reading the lower byte-count word latches counter bits 47..32 into upper register.
// - software reads lower then upper; byte counter clears after both are read.
// - byte counter adds every byte from address through check sequence, wraps at maximum.
// - frames-sent counter increments once per successfully transmitted frame.
// - frame counters saturate at their maximum and hold it until read.
// - reading a frame counter returns its value then clears it; reset clears all.
// - broadcast counter counts good frames whose destination address is all ones.
// - group-address counter counts good frames whose first destination bit is one.
// - minimum bin counts good frames exactly 64 bytes long.
// - bin one counts good frames of 65 through 127 bytes.
// - bin two counts good frames of 128 through 255 bytes.
// - bin three counts good frames of 256 through 511 bytes.
// - bin four counts good frames of 512 through 1023 bytes.
`ifndef MTSC_REGS_VH
`define MTSC_REGS_VH

// **************************************************************
// register indices (byte address is four times the index)
// **************************************************************
`define MTSC_IDX_BYTE_LOWER   8'h30
`define MTSC_IDX_BYTE_UPPER   8'h31
`define MTSC_IDX_FRAMES_GOOD  8'h32
`define MTSC_IDX_BCAST_GOOD   8'h33
`define MTSC_IDX_GROUP_GOOD   8'h34
`define MTSC_IDX_LEN_MIN      8'h35
`define MTSC_IDX_LEN_BIN1     8'h36
`define MTSC_IDX_LEN_BIN2     8'h37
`define MTSC_IDX_LEN_BIN3     8'h38
`define MTSC_IDX_LEN_BIN4     8'h39

// **************************************************************
// fields, limits and reset values
// **************************************************************
`define MTSC_BYTE_CNT_W       48
`define MTSC_UPPER_HI         47
`define MTSC_UPPER_LO         32
`define MTSC_FRAME_CNT_MAX    32'h0fffffff
`define MTSC_RESET_VAL        32'h00000000
`define MTSC_LEN_W            16
`define MTSC_LEN_MIN          16'h0040
`define MTSC_LEN_BIN1_LO      16'h0041
`define MTSC_LEN_BIN1_HI      16'h007f
`define MTSC_LEN_BIN2_LO      16'h0080
`define MTSC_LEN_BIN2_HI      16'h00ff
`define MTSC_LEN_BIN3_LO      16'h0100
`define MTSC_LEN_BIN3_HI      16'h01ff
`define MTSC_LEN_BIN4_LO      16'h0200
`define MTSC_LEN_BIN4_HI      16'h03ff
`define MTSC_NUM_FRAME_CNT    8

`endif

// ### src/mtsc_sat_counter.v
// one saturating clear-on-read frame counter
// assumes events and read strobes are synchronous single-cycle pulses
`include "mtsc_regs.vh"
`timescale 1ns/100ps
module mtsc_sat_counter #(
   parameter [31:0] MAX_VAL = `MTSC_FRAME_CNT_MAX
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   input  wire        inc_i,
   input  wire        clr_i,
   output wire [31:0] cnt_o
);
   reg [31:0] cnt_q;
   reg [31:0] cnt_d;

   always @* begin
      cnt_d = cnt_q;
      if (clr_i) begin
         cnt_d = inc_i ? 32'h00000001 : `MTSC_RESET_VAL;
      end else if (inc_i && (cnt_q < MAX_VAL)) begin
         cnt_d = cnt_q + 32'h00000001;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= `MTSC_RESET_VAL;
      end else if (ce_i) begin
         cnt_q <= cnt_d;
      end
   end

   assign cnt_o = cnt_q;
endmodule // mtsc_sat_counter

// ### src/mtsc_tx_stats.v
// transmit statistics counters with a classic wishbone slave
// assumes frame report pulses from the mac transmit path in the clk_i domain
//
// Design decision made here: register access over Wishbone.
`include "mtsc_regs.vh"
`timescale 1ns/100ps
module mtsc_tx_stats #(
   parameter        ADR_W   = 10,
   parameter [31:0] CNT_MAX = `MTSC_FRAME_CNT_MAX
) (
   input  wire                   clk_i,
   input  wire                   rst_i,
   input  wire                   ce_i,
   // wishbone classic slave
   input  wire                   cyc_i,
   input  wire                   stb_i,
   input  wire                   we_i,
   input  wire [ADR_W-1:0]       adr_i,
   input  wire [3:0]             sel_i,
   input  wire [31:0]            dat_i,
   output reg  [31:0]            dat_o,
   output reg                    ack_o,
   // mac transmit path
   input  wire                   tx_byte_vld_i,
   input  wire                   tx_done_i,
   input  wire                   tx_ok_i,
   input  wire [47:0]            tx_dst_addr_i,
   input  wire [`MTSC_LEN_W-1:0] tx_len_i
);

   // ***********************************************************
   // helpers
   // ***********************************************************
   function in_range;
      input [`MTSC_LEN_W-1:0] len;
      input [`MTSC_LEN_W-1:0] lo;
      input [`MTSC_LEN_W-1:0] hi;
      begin
         in_range = (len >= lo) && (len <= hi);
      end
   endfunction

   // ***********************************************************
   // bus decode
   // ***********************************************************
   wire [7:0] idx    = adr_i[9:2];
   wire       req    = cyc_i && stb_i && !ack_o;
   wire       rd_req = req && !we_i;

   wire rd_lower = rd_req && (idx == `MTSC_IDX_BYTE_LOWER);
   wire rd_upper = rd_req && (idx == `MTSC_IDX_BYTE_UPPER);

   // ***********************************************************
   // frame classification
   // ***********************************************************
   wire good = tx_done_i && tx_ok_i;
   wire [`MTSC_NUM_FRAME_CNT-1:0] inc;
   assign inc[0] = good;
   assign inc[1] = good && (&tx_dst_addr_i);
   assign inc[2] = good && tx_dst_addr_i[40];
   assign inc[3] = good && (tx_len_i == `MTSC_LEN_MIN);
   assign inc[4] = good && in_range(tx_len_i, `MTSC_LEN_BIN1_LO,
                                    `MTSC_LEN_BIN1_HI);
   assign inc[5] = good && in_range(tx_len_i, `MTSC_LEN_BIN2_LO,
                                    `MTSC_LEN_BIN2_HI);
   assign inc[6] = good && in_range(tx_len_i, `MTSC_LEN_BIN3_LO,
                                    `MTSC_LEN_BIN3_HI);
   assign inc[7] = good && in_range(tx_len_i, `MTSC_LEN_BIN4_LO,
                                    `MTSC_LEN_BIN4_HI);

   // ***********************************************************
   // frame counters
   // ***********************************************************
   wire [31:0] cnt [0:`MTSC_NUM_FRAME_CNT-1];
   genvar g;
   generate
      for (g = 0; g < `MTSC_NUM_FRAME_CNT; g = g + 1) begin : g_cnt
         mtsc_sat_counter #(
            .MAX_VAL (CNT_MAX)
         ) u_cnt (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .ce_i  (ce_i),
            .inc_i (inc[g]),
            .clr_i (rd_req && (idx == `MTSC_IDX_FRAMES_GOOD + g)),
            .cnt_o (cnt[g])
         );
      end
   endgenerate

   // ***********************************************************
   // 48-bit byte counter with snapshot
   // ***********************************************************
   reg [47:0] byte_cnt_q;
   reg [47:0] byte_cnt_d;
   reg [15:0] upper_q;
   reg        lower_rd_q;
   reg        upper_rd_q;

   wire both_read = (lower_rd_q || rd_lower) && (upper_rd_q || rd_upper);

   always @* begin
      byte_cnt_d = byte_cnt_q + {47'd0, tx_byte_vld_i};
      if (both_read) begin
         byte_cnt_d = {47'd0, tx_byte_vld_i};
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         byte_cnt_q <= 48'h000000000000;
         upper_q    <= 16'h0000;
         lower_rd_q <= 1'b0;
         upper_rd_q <= 1'b0;
      end else if (ce_i) begin
         byte_cnt_q <= byte_cnt_d;
         if (rd_lower) begin
            upper_q <= byte_cnt_q[`MTSC_UPPER_HI:`MTSC_UPPER_LO];
         end
         if (both_read) begin
            lower_rd_q <= 1'b0;
            upper_rd_q <= 1'b0;
         end else begin
            lower_rd_q <= lower_rd_q || rd_lower;
            upper_rd_q <= upper_rd_q || (rd_upper && lower_rd_q);
         end
      end
   end

   // ***********************************************************
   // read mux and ack
   // ***********************************************************
   reg [31:0] rdata;
   always @* begin
      rdata = 32'h00000000;
      case (idx)
         `MTSC_IDX_BYTE_LOWER:  rdata = byte_cnt_q[31:0];
         `MTSC_IDX_BYTE_UPPER:  rdata = {16'h0000, upper_q};
         `MTSC_IDX_FRAMES_GOOD: rdata = cnt[0];
         `MTSC_IDX_BCAST_GOOD:  rdata = cnt[1];
         `MTSC_IDX_GROUP_GOOD:  rdata = cnt[2];
         `MTSC_IDX_LEN_MIN:     rdata = cnt[3];
         `MTSC_IDX_LEN_BIN1:    rdata = cnt[4];
         `MTSC_IDX_LEN_BIN2:    rdata = cnt[5];
         `MTSC_IDX_LEN_BIN3:    rdata = cnt[6];
         `MTSC_IDX_LEN_BIN4:    rdata = cnt[7];
         default:               rdata = 32'h00000000;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else if (ce_i) begin
         ack_o <= req;
         if (rd_req) begin
            dat_o <= rdata;
         end
      end
   end
endmodule // mtsc_tx_stats

// ### bench/mtsc_tx_stats_props.sv
// assertions on the wishbone side of the tx statistics block
// assumes word index in adr_i[9:2] and one clock domain
`timescale 1ns/100ps
module mtsc_tx_stats_props #(
   parameter        ADR_W   = 10,
   parameter [31:0] CNT_MAX = 32'h0fffffff
) (
   input wire             clk_i,
   input wire             rst_i,
   input wire             ce_i,
   input wire             cyc_i,
   input wire             stb_i,
   input wire [ADR_W-1:0] adr_i,
   input wire [31:0]      dat_o,
   input wire             ack_o,
   input wire             tx_done_i,
   input wire             tx_ok_i
);
   // ************************************
   // request decode and properties
   // ************************************
   wire [7:0] idx  = adr_i[9:2];
   wire       take = cyc_i & stb_i & ~ack_o & ce_i;
   wire       ev   = tx_done_i & tx_ok_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_next: assert property (take |=> ack_o) else $error("no ack after request");
   chk_ack_pulse: assert property (ack_o && ce_i |=> !ack_o) else $error("ack too long");
   chk_no_stray: assert property (!take && ce_i |=> !ack_o) else $error("ack without request");
   chk_dat_hold: assert property (!ack_o |-> $stable(dat_o)) else $error("read data moved");
   chk_upper_zero: assert property (
      ack_o && idx == 8'h31 |-> dat_o[31:16] == 16'h0) else $error("upper half not zero");
   chk_sat_max: assert property (
      ack_o && idx >= 8'h32 && idx <= 8'h39 |-> dat_o <= CNT_MAX) else $error("above max");
   chk_unmapped_zero: assert property (ack_o && idx > 8'h39 |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   chk_clear_read: assert property (
      (take && idx == 8'h32 && !ev) ##1 (!ev) [*3] ##0 (take && idx == 8'h32) |=> dat_o == 32'h0)
      else $error("counter not cleared by read");
endmodule // mtsc_tx_stats_props
bind mtsc_tx_stats mtsc_tx_stats_props #(.ADR_W(ADR_W), .CNT_MAX(CNT_MAX)) u_props (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .adr_i(adr_i),
   .dat_o(dat_o), .ack_o(ack_o), .tx_done_i(tx_done_i), .tx_ok_i(tx_ok_i));

// ### bench/tb.sv
// self-checking bench for the tx statistics counters
// assumes a 25 MHz clock and a saturation limit lowered to 0xf
`timescale 1ns/100ps
module tb;
   logic        clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [9:0]  adr_i = 10'h0;
   logic [3:0]  sel_i = 4'hf;
   logic [31:0] dat_i = 32'h0;
   logic        tx_byte_vld_i = 0, tx_done_i = 0, tx_ok_i = 0;
   logic [47:0] tx_dst_addr_i = 48'h0, bytes = 48'h0;
   logic [15:0] tx_len_i = 16'h0;
   wire  [31:0] dat_o;
   wire         ack_o;
   int          fail_count = 0, cmp_count = 0, i;
   logic [15:0] lens [11] = '{16'h3f, 16'h40, 16'h41, 16'h7f, 16'h80, 16'hff, 16'h100,
                              16'h1ff, 16'h200, 16'h3ff, 16'h400};
   logic [7:0]  expv [8] = '{8'hb, 8'h1, 8'h2, 8'h1, 8'h2, 8'h2, 8'h2, 8'h2};
   mtsc_tx_stats #(.CNT_MAX(32'h0000000f)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .tx_byte_vld_i(tx_byte_vld_i), .tx_done_i(tx_done_i),
      .tx_ok_i(tx_ok_i), .tx_dst_addr_i(tx_dst_addr_i), .tx_len_i(tx_len_i));
   always #20 clk_i = ~clk_i;
   // ************************************
   // tasks
   // ************************************
   task report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input [7:0] nm, input [31:0] got, input [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value reg %h expected %h seen %h", nm, exp, got);
      end
   endtask
   // one wishbone cycle; ev puts a good frame end on the taking edge
   task rd(input [7:0] idx, input [31:0] exp, input ev, input w);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      if (ev) begin
         tx_done_i <= 1'b1;
         tx_ok_i <= 1'b1;
      end
      do begin
         @(posedge clk_i);
         if (ev && n == 0) begin
            tx_done_i <= 1'b0;
            tx_ok_i <= 1'b0;
         end
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         report_and_stop;
      end else begin
         cyc_i <= 1'b0;
         stb_i <= 1'b0;
         we_i <= 1'b0;
         if (!w) chk(idx, dat_o, exp);
         @(posedge clk_i);
      end
   endtask
   task frame(input [47:0] da, input [15:0] len, input ok, input int nb);
      repeat (nb) begin
         tx_byte_vld_i <= 1'b1;
         @(posedge clk_i);
      end
      tx_byte_vld_i <= 1'b0;
      tx_done_i <= 1'b1;
      tx_ok_i <= ok;
      tx_dst_addr_i <= da;
      tx_len_i <= len;
      @(posedge clk_i);
      tx_done_i <= 1'b0;
      tx_ok_i <= 1'b0;
      bytes = bytes + nb;
      @(posedge clk_i);
   endtask
   // ************************************
   // sequence
   // ************************************
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 1; i < 10; i++) rd(8'h30 + i, 32'h0, 0, 0);
      for (i = 0; i < 11; i++)
         frame(i == 0 ? 48'hffffffffffff : i == 1 ? 48'h010000000001 : 48'h020000000001,
               lens[i], 1'b1, lens[i]);
      frame(48'hffffffffffff, 16'h40, 1'b0, 64);
      rd(8'h33, 32'h0, 0, 1);
      for (i = 0; i < 8; i++) begin
         rd(8'h32 + i, {24'h0, expv[i]}, 0, 0);
         rd(8'h32 + i, 32'h0, 0, 0);
      end
      rd(8'h3a, 32'h0, 0, 0);
      rd(8'h30, bytes[31:0], 0, 0);
      rd(8'h31, {16'h0, bytes[47:32]}, 0, 0);
      rd(8'h30, 32'h0, 0, 0);
      repeat (20) frame(48'h020000000001, 16'h40, 1'b1, 0);
      rd(8'h32, 32'hf, 0, 0);
      rd(8'h35, 32'hf, 0, 0);
      frame(48'h020000000001, 16'h40, 1'b1, 0);
      rd(8'h32, 32'h1, 1, 0);
      rd(8'h32, 32'h1, 0, 0);
      report_and_stop;
   end
endmodule // tb
